// File: verilog/aoc_defines.svh
`ifndef AOC_DEFINES_SVH
`define AOC_DEFINES_SVH

// ==========================================================
// Page and register offsets
`define AOC_PAGE_NUM        8'h01
`define AOC_OFS_GAIN        8'h02
`define AOC_OFS_MUTE        8'h06
`define AOC_OFS_BOOST       8'h07
`define AOC_OFS_PINFN       8'h09

// ==========================================================
// Field positions
`define AOC_BIT_LEFT        4
`define AOC_BIT_RIGHT       0
`define AOC_BIT_MUTE        0
`define AOC_BIT_DEEMPH      1
`define AOC_BIT_REFPD       0

// ==========================================================
// Reset values
`define AOC_RST_GAIN        8'h00
`define AOC_RST_MUTE        8'h01
`define AOC_RST_BOOST       8'h00
`define AOC_RST_PINFN       8'h01
// Control outputs in aoc_ctrl_type field order: tracking and power-down set
`define AOC_RST_CTRL        7'h11

// ==========================================================
// Zero byte; no writable bit masks, since reserved bits are also stored
`define AOC_ZERO_BYTE       8'h00

`endif

// File: verilog/aoc_pkg.sv
package aoc_pkg;

  // ==========================================================
  // Register access request from the control-bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aoc_req_type;

  // ==========================================================
  // Control bits delivered to the analog stages
  typedef struct packed {
    logic left_gain_attenuate;
    logic right_gain_attenuate;
    logic mute_follow_enable;
    logic left_amplitude_boost;
    logic right_amplitude_boost;
    logic deemphasis_pin_enable;
    logic reference_powerdown;
  } aoc_ctrl_type;

  // ==========================================================
  // Register bank contents
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] mute;
    logic [7:0] boost;
    logic [7:0] pinfn;
  } aoc_bank_type;

endpackage

// File: verilog/aoc_decode.sv
`timescale 1ns/1ps
`include "aoc_defines.svh"

// Page and offset decoder: one-hot select of the four registers
module aoc_decode
  import aoc_pkg::*;
(
  // ==========================================================
  // Access
  input  wire logic [7:0] page_i,
  input  wire logic [7:0] addr_i,
  // ==========================================================
  // Selects
  output      logic [3:0] sel_o,
  output      logic       hit_o
);

  function automatic logic match(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] ofs);
    match = (pg == `AOC_PAGE_NUM) && (a == ofs);
  endfunction

  // Other pages never reach this bank
  always_comb begin
    sel_o[0] = match(page_i, addr_i, `AOC_OFS_GAIN);
    sel_o[1] = match(page_i, addr_i, `AOC_OFS_MUTE);
    sel_o[2] = match(page_i, addr_i, `AOC_OFS_BOOST);
    sel_o[3] = match(page_i, addr_i, `AOC_OFS_PINFN);
    hit_o    = |sel_o;
  end

endmodule

// File: verilog/aoc_regs.sv
`timescale 1ns/1ps
`include "aoc_defines.svh"

// How it works
// - Gain bit 4 attenuates left analog gain by 6 dB; resets 0.
// - Gain bit 0 attenuates right analog gain by 6 dB; resets 0.
// - Mute-tracking bit 0 lets analog mute follow digital mute; resets 1.
// - Boost bit 4 raises left amplitude 10 percent; resets 0.
// - Boost bit 0 raises right amplitude 10 percent; resets 0.
// - Pin-function bit 1 makes shared pin the de-emphasis input; resets 0.
// - Pin-function bit 0 powers reference down when set; resets 1.
// - These registers live on page 1; other pages do not reach them.
module aoc_regs
  import aoc_pkg::*;
(
  // ==========================================================
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  // ==========================================================
  // Register access
  input  wire aoc_req_type  req_i,
  output      logic [7:0]   rdata_o,
  output      logic         rvalid_o,
  // ==========================================================
  // Analog controls
  output      aoc_ctrl_type ctrl_o
);

  // ==========================================================
  // State
  typedef struct packed {
    aoc_bank_type bank;
    logic [7:0]   rdata;
    logic         rvalid;
    aoc_ctrl_type ctrl;
  } aoc_state_type;

  aoc_state_type state_r;
  aoc_state_type state_nxt;
  logic [3:0]    sel;
  logic          hit;

  aoc_decode i_aoc_decode (
    .page_i (req_i.page),
    .addr_i (req_i.addr),
    .sel_o  (sel),
    .hit_o  (hit)
  );

  // ==========================================================
  // Next-state logic
  // Reserved bits are stored as written so read-back matches; software keeps them zero
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    if (req_i.wr) begin
      if (sel[0]) state_nxt.bank.gain  = req_i.wdata;
      if (sel[1]) state_nxt.bank.mute  = req_i.wdata;
      if (sel[2]) state_nxt.bank.boost = req_i.wdata;
      if (sel[3]) state_nxt.bank.pinfn = req_i.wdata;
    end
    if (req_i.rd) begin
      state_nxt.rvalid = 1'b1;
      unique case (1'b1)
        sel[0]:  state_nxt.rdata = state_r.bank.gain;
        sel[1]:  state_nxt.rdata = state_r.bank.mute;
        sel[2]:  state_nxt.rdata = state_r.bank.boost;
        sel[3]:  state_nxt.rdata = state_r.bank.pinfn;
        default: state_nxt.rdata = `AOC_ZERO_BYTE;
      endcase
    end
    // Controls are registered so the analog side sees glitch-free levels
    state_nxt.ctrl.left_gain_attenuate   = state_nxt.bank.gain[`AOC_BIT_LEFT];
    state_nxt.ctrl.right_gain_attenuate  = state_nxt.bank.gain[`AOC_BIT_RIGHT];
    state_nxt.ctrl.mute_follow_enable    = state_nxt.bank.mute[`AOC_BIT_MUTE];
    state_nxt.ctrl.left_amplitude_boost  = state_nxt.bank.boost[`AOC_BIT_LEFT];
    state_nxt.ctrl.right_amplitude_boost = state_nxt.bank.boost[`AOC_BIT_RIGHT];
    state_nxt.ctrl.deemphasis_pin_enable = state_nxt.bank.pinfn[`AOC_BIT_DEEMPH];
    state_nxt.ctrl.reference_powerdown   = state_nxt.bank.pinfn[`AOC_BIT_REFPD];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_r.bank.gain  <= `AOC_RST_GAIN;
      state_r.bank.mute  <= `AOC_RST_MUTE;
      state_r.bank.boost <= `AOC_RST_BOOST;
      state_r.bank.pinfn <= `AOC_RST_PINFN;
      state_r.rdata      <= `AOC_ZERO_BYTE;
      state_r.rvalid     <= 1'b0;
      state_r.ctrl       <= `AOC_RST_CTRL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o  = state_r.rdata;
  assign rvalid_o = state_r.rvalid;
  assign ctrl_o   = state_r.ctrl;

  // ==========================================================
  // Checks
  property p_left_gain;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[0]) |=> (ctrl_o.left_gain_attenuate == $past(req_i.wdata[`AOC_BIT_LEFT]));
  endproperty
  a_left_gain: assert property (p_left_gain) else $error("left gain not updated");

  property p_right_gain;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[0]) |=> (ctrl_o.right_gain_attenuate == $past(req_i.wdata[`AOC_BIT_RIGHT]));
  endproperty
  a_right_gain: assert property (p_right_gain) else $error("right gain not updated");

  property p_mute_reset;
    @(posedge core_clk_i) $rose(nrst_i) |-> ctrl_o.mute_follow_enable && ctrl_o.reference_powerdown;
  endproperty
  a_mute_reset: assert property (p_mute_reset) else $error("reset value wrong");

  property p_left_boost;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[2]) |=> (ctrl_o.left_amplitude_boost == $past(req_i.wdata[`AOC_BIT_LEFT]));
  endproperty
  a_left_boost: assert property (p_left_boost) else $error("left boost wrong");

  property p_right_boost;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[2]) |=> (ctrl_o.right_amplitude_boost == $past(req_i.wdata[`AOC_BIT_RIGHT]));
  endproperty
  a_right_boost: assert property (p_right_boost) else $error("right boost wrong");

  property p_deemph_pin;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[3]) |=> (ctrl_o.deemphasis_pin_enable == $past(req_i.wdata[`AOC_BIT_DEEMPH]));
  endproperty
  a_deemph_pin: assert property (p_deemph_pin) else $error("de-emphasis enable wrong");

  property p_refpd_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(req_i.wr && sel[3]) |=> $stable(ctrl_o.reference_powerdown);
  endproperty
  a_refpd_hold: assert property (p_refpd_hold) else $error("powerdown changed without write");

  property p_page_miss;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && req_i.page != `AOC_PAGE_NUM) |=> $stable(state_r.bank);
  endproperty
  a_page_miss: assert property (p_page_miss) else $error("other page reached bank");

  property p_read_back;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.rd && !req_i.wr && sel[1]) |=> rvalid_o && (rdata_o == $past(state_r.bank.mute));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_mute_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[1]) |=> (ctrl_o.mute_follow_enable == $past(req_i.wdata[`AOC_BIT_MUTE]));
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("mute tracking not updated");

  property p_refpd_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && sel[3]) |=> (ctrl_o.reference_powerdown == $past(req_i.wdata[`AOC_BIT_REFPD]));
  endproperty
  a_refpd_write: assert property (p_refpd_write) else $error("powerdown not updated");

  // Hold checks catch a decode slip that lets one register's write disturb another
  property p_gain_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(req_i.wr && sel[0]) |=> $stable(ctrl_o.left_gain_attenuate) && $stable(ctrl_o.right_gain_attenuate);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

  property p_boost_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(req_i.wr && sel[2]) |=> $stable(ctrl_o.left_amplitude_boost) && $stable(ctrl_o.right_amplitude_boost);
  endproperty
  a_boost_hold: assert property (p_boost_hold) else $error("boost changed without write");

  property p_mute_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(req_i.wr && sel[1]) |=> $stable(ctrl_o.mute_follow_enable);
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("mute tracking changed without write");

  property p_deemph_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !(req_i.wr && sel[3]) |=> $stable(ctrl_o.deemphasis_pin_enable);
  endproperty
  a_deemph_hold: assert property (p_deemph_hold) else $error("de-emphasis changed without write");

  property p_read_zero;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.rd && !hit) |=> rvalid_o && (rdata_o == `AOC_ZERO_BYTE);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("missed read not zero");

  property p_read_gain;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.rd && sel[0]) |=> rvalid_o && (rdata_o == $past(state_r.bank.gain));
  endproperty
  a_read_gain: assert property (p_read_gain) else $error("gain read data wrong");

  property p_read_pinfn;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.rd && sel[3]) |=> rvalid_o && (rdata_o == $past(state_r.bank.pinfn));
  endproperty
  a_read_pinfn: assert property (p_read_pinfn) else $error("pin-function read data wrong");

  property p_rvalid_pulse;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !req_i.rd |=> !rvalid_o;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

  property p_ctrl_reset;
    @(posedge core_clk_i) $rose(nrst_i) |->
      !ctrl_o.left_gain_attenuate && !ctrl_o.right_gain_attenuate && !ctrl_o.left_amplitude_boost &&
      !ctrl_o.right_amplitude_boost && !ctrl_o.deemphasis_pin_enable && !rvalid_o &&
      (rdata_o == `AOC_ZERO_BYTE);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("cleared reset value wrong");

  // ==========================================================
  // Scenarios
  c_write_gain:  cover property (@(posedge core_clk_i) req_i.wr && sel[0]);
  c_read_pinfn:  cover property (@(posedge core_clk_i) req_i.rd && sel[3]);
  c_miss_read:   cover property (@(posedge core_clk_i) req_i.rd && !hit);
  c_write_mute:  cover property (@(posedge core_clk_i) req_i.wr && sel[1]);
  c_miss_write:  cover property (@(posedge core_clk_i) req_i.wr && (req_i.page != `AOC_PAGE_NUM));

endmodule

// File: sim/aoc_host.sv
`timescale 1ns/1ps

// ==========================================================
// Host software model: one access per read or write call (rmw makes two), one idle cycle after each
module aoc_host
  import aoc_pkg::*;
(
  // Clock
  input  wire logic        core_clk_i,
  // Device side
  output      aoc_req_type req_o,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        rvalid_i
);
  initial req_o = '0;

  // Released fields show inverted values so stale data never looks valid
  task automatic idle(input aoc_req_type r);
    req_o = '{wr: 1'b0, rd: 1'b0, page: ~r.page, addr: ~r.addr, wdata: ~r.wdata};
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    req_o = '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
    @(posedge core_clk_i);
    #1 idle(req_o);
  endtask

  task automatic rd_reg(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d, output logic ok);
    req_o = '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
    @(posedge core_clk_i);
    #1 ok = rvalid_i;
    d = rdata_i;
    idle(req_o);
  endtask

  // Change one bit and keep the rest of the byte intact
  task automatic rmw(input logic [7:0] ad, input int b, input logic v);
    logic [7:0] d;
    logic       ok;
    rd_reg(8'h01, ad, d, ok);
    d[b] = v;
    wr_reg(8'h01, ad, d);
  endtask
endmodule

// File: sim/aoc_regs_tb.sv
`timescale 1ns/1ps

module aoc_regs_tb
  import aoc_pkg::*;
;
  logic         core_clk_i = 1'b0;
  logic         nrst_i     = 1'b0;
  aoc_req_type  req;
  logic [7:0]   rdata;
  logic         rvalid;
  aoc_ctrl_type ctrl;
  int           error_cnt   = 0;
  int           comparisons = 0;
  int           cyc         = 0;
  logic [7:0]   ofs [4] = '{8'h02, 8'h06, 8'h07, 8'h09};
  logic [7:0]   msk [4] = '{8'h11, 8'h01, 8'h11, 8'h03};
  logic [7:0]   exp [4] = '{8'h00, 8'h01, 8'h00, 8'h01};

  // ==========================================================
  // Clock, device and host
  initial forever #2.5 core_clk_i = ~core_clk_i;

  aoc_regs i_aoc_regs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
                       .rvalid_o(rvalid), .ctrl_o(ctrl));
  aoc_host i_aoc_host (.core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ==========================================================
  // Checks
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask

  task automatic chk_ctrl();
    aoc_ctrl_type e;
    e = '{exp[0][4], exp[0][0], exp[1][0], exp[2][4], exp[2][0], exp[3][1], exp[3][0]};
    chk(ctrl === e, "ctrl mismatch");
  endtask

  task automatic rd_chk(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    i_aoc_host.rd_reg(pg, ad, d, ok);
    chk(ok === 1'b1 && d === e, "read mismatch");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // A clean run needs about a hundred cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    chk_ctrl();
    for (int i = 0; i < 4; i++) rd_chk(8'h01, ofs[i], exp[i]);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 8; j++) begin
        if (msk[i][j]) begin
          exp[i] = 8'h01 << j;
          i_aoc_host.wr_reg(8'h01, ofs[i], exp[i]);
          chk_ctrl();
          rd_chk(8'h01, ofs[i], exp[i]);
        end
      end
      exp[i] = 8'h00;
      i_aoc_host.wr_reg(8'h01, ofs[i], 8'h00);
      chk_ctrl();
    end
    $display("Test field walk done");
    for (int i = 0; i < 4; i++) begin
      i_aoc_host.wr_reg(8'h00, ofs[i], msk[i]);
      i_aoc_host.wr_reg(8'h02, ofs[i], msk[i]);
      chk_ctrl();
      rd_chk(8'h00, ofs[i], 8'h00);
      rd_chk(8'h01, ofs[i], 8'h00);
    end
    rd_chk(8'h01, 8'h03, 8'h00);
    $display("Test page and offset decode done");
    i_aoc_host.wr_reg(8'h01, ofs[3], 8'h01);
    i_aoc_host.rmw(ofs[3], 1, 1'b1);
    exp[3] = 8'h03;
    chk_ctrl();
    rd_chk(8'h01, ofs[3], 8'h03);
    $display("Test read-modify-write done");
    nrst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    exp = '{8'h00, 8'h01, 8'h00, 8'h01};
    chk_ctrl();
    rd_chk(8'h01, ofs[1], 8'h01);
    rd_chk(8'h01, ofs[3], 8'h01);
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule
